// ===== src/tpm_pkg.sv
// Shared types and constants for the four-way transmit packet merge
// Assumes one transmit clock shared by the MAC side and all four sources
package tpm_pkg;

  // ==========================================================================
  // Sizes
  localparam int TPM_CHANNELS   = 4;
  localparam int TPM_SEL_W      = 2;
  localparam int TPM_WORD_W     = 512;
  localparam int TPM_FIFO_DEPTH = 8;

  // ==========================================================================
  // Reset values
  localparam logic [1:0] TPM_SEL_RESET = 2'h3;

  // ==========================================================================
  // Link clock rates, in MHz
  localparam real TPM_SOFT_MAC_MHZ = 390.625;
  localparam real TPM_HARD_MAC_MHZ = 402.832;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic                  first;
    logic                  last;
    logic [TPM_WORD_W-1:0] word;
  } tpm_beat_t;

  localparam int TPM_BEAT_W = $bits(tpm_beat_t);

  typedef struct packed {
    logic                  valid;
    logic                  first;
    logic                  last;
    logic [TPM_WORD_W-1:0] word;
  } tpm_rx_t;

  typedef enum logic [0:0] {
    TPM_IDLE,
    TPM_SEND
  } tpm_state_t;

endpackage

// ===== src/tpm_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
// Assumes a single clock; depth is a power of two
`timescale 1ns/1ps
`default_nettype none
module tpm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    nxt_wrPtr;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW-1:0]    nxt_rdPtr;
  logic [AW:0]      count_ff;
  logic [AW:0]      nxt_count;
  logic             push;
  logic             pop;

  // ==========================================================================
  // Flags
  assign inReady  = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem_ff[rdPtr_ff];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // ==========================================================================
  // Pointers
  always_comb begin
    nxt_wrPtr = push ? wrPtr_ff + 1'b1 : wrPtr_ff;
    nxt_rdPtr = pop ? rdPtr_ff + 1'b1 : rdPtr_ff;
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end

  // Storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

endmodule
`default_nettype wire

// ===== src/tpm_merge.sv
// Four-way transmit packet merge onto one MAC transmit stream
// Assumes sources and MAC share ref_clk, the MAC transmit clock
`timescale 1ns/1ps
`default_nettype none
module tpm_merge (
  input  wire logic                                      ref_clk,
  input  wire logic                                      resetn,
  input  wire logic               [3:0]                  sourceSendValid,
  output logic                    [3:0]                  sourceSendReady,
  input  wire tpm_pkg::tpm_beat_t [3:0]                  sourceBeat,
  output logic                                           source_send_valid,
  input  wire logic                                      source_send_ready,
  output tpm_pkg::tpm_beat_t                             macTxBeat,
  input  wire tpm_pkg::tpm_rx_t                          macRx,
  output tpm_pkg::tpm_rx_t        [3:0]                  engineRx,
  output logic                    [tpm_pkg::TPM_SEL_W-1:0] activeChannelSelect
);
  import tpm_pkg::*;

  // single ref_clk domain, the MAC transmit clock

  tpm_state_t           state_ff;
  tpm_state_t           nxt_state;
  logic [TPM_SEL_W-1:0] sel_ff;
  logic [TPM_SEL_W-1:0] nxt_sel;
  tpm_beat_t            pendingWordLatch_ff;
  tpm_beat_t            nxt_pendingWordLatch;
  logic                 pendingFull_ff;
  logic                 nxt_pendingFull;
  tpm_beat_t            out_ff;
  logic                 outValid_ff;
  tpm_beat_t            nxt_out;
  logic                 nxt_outValid;
  logic                 srcTake;
  logic                 fifoInReady;
  logic                 fifoOutValid;
  logic                 fifoOutReady;
  tpm_beat_t            fifoOut;
  logic [TPM_SEL_W-1:0] pick;
  logic                 pickHit;
  logic [TPM_SEL_W-1:0] cand;
  tpm_beat_t            curBeat;

  // ==========================================================================
  // Receive fan-out
  always_comb begin
    for (int i = 0; i < TPM_CHANNELS; i++) begin
      engineRx[i] = macRx;
    end
  end

  // ==========================================================================
  // Round-robin pick
  always_comb begin
    pick    = sel_ff;
    pickHit = 1'b0;
    cand    = sel_ff;
    for (int k = 1; k <= TPM_CHANNELS; k++) begin
      cand = sel_ff + TPM_SEL_W'(k);
      if (!pickHit && sourceSendValid[cand]) begin
        pick    = cand;
        pickHit = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Source acceptance
  assign curBeat = sourceBeat[sel_ff];
  assign srcTake = (state_ff == TPM_SEND) && sourceSendValid[sel_ff] && fifoInReady
                   && source_send_ready;

  always_comb begin
    sourceSendReady = '0;
    if (state_ff == TPM_SEND) begin
      sourceSendReady[sel_ff] = fifoInReady && source_send_ready;
    end
  end

  // ==========================================================================
  // Grant state
  always_comb begin
    nxt_state = state_ff;
    nxt_sel   = sel_ff;
    case (state_ff)
      TPM_IDLE: begin
        if (pickHit) begin
          nxt_sel   = pick;
          nxt_state = TPM_SEND;
        end
      end
      TPM_SEND: begin
        if (srcTake && curBeat.last) begin
          nxt_state = TPM_IDLE;
        end
      end
      default: begin
        nxt_state = TPM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= TPM_IDLE;
      sel_ff   <= TPM_SEL_RESET;
    end else begin
      state_ff <= nxt_state;
      sel_ff   <= nxt_sel;
    end
  end

  assign activeChannelSelect = sel_ff;

  // ==========================================================================
  // Beat buffer between sources and MAC stage
  tpm_fifo #(
    .WIDTH (TPM_BEAT_W),
    .DEPTH (TPM_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .inValid  (srcTake),
    .inReady  (fifoInReady),
    .inData   (curBeat),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOut)
  );

  // ==========================================================================
  // Pending latch and MAC output stage
  always_comb begin
    nxt_pendingWordLatch = pendingWordLatch_ff;
    nxt_pendingFull      = pendingFull_ff;
    nxt_out              = out_ff;
    nxt_outValid         = outValid_ff;
    fifoOutReady         = 1'b0;
    if (!outValid_ff || source_send_ready) begin
      if (pendingFull_ff) begin
        nxt_out         = pendingWordLatch_ff;
        nxt_outValid    = 1'b1;
        nxt_pendingFull = 1'b0;
        fifoOutReady    = 1'b1;
        if (fifoOutValid) begin
          nxt_pendingWordLatch = fifoOut;
          nxt_pendingFull      = 1'b1;
        end
      end else begin
        fifoOutReady = 1'b1;
        nxt_out      = fifoOut;
        nxt_outValid = fifoOutValid;
      end
    end else if (!pendingFull_ff) begin
      fifoOutReady = 1'b1;
      if (fifoOutValid) begin
        nxt_pendingWordLatch = fifoOut;
        nxt_pendingFull      = 1'b1;
      end
    end
    // Else hold everything toward the MAC
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pendingWordLatch_ff <= '0;
      pendingFull_ff      <= 1'b0;
      out_ff              <= '0;
      outValid_ff         <= 1'b0;
    end else begin
      pendingWordLatch_ff <= nxt_pendingWordLatch;
      pendingFull_ff      <= nxt_pendingFull;
      out_ff              <= nxt_out;
      outValid_ff         <= nxt_outValid;
    end
  end

  assign source_send_valid = outValid_ff;
  assign macTxBeat  = out_ff;

endmodule
`default_nettype wire

// ===== verification/tpm_merge_assertions.sv
// Port checker for tpm_merge
// Bound to every tpm_merge instance, one clock
`timescale 1ns/1ps
`default_nettype none
module tpm_merge_assertions (
  input wire logic                        ref_clk,
  input wire logic                        resetn,
  input wire logic [3:0]                  sourceSendValid,
  input wire logic [3:0]                  sourceSendReady,
  input wire tpm_pkg::tpm_beat_t [3:0]    sourceBeat,
  input wire logic                        source_send_valid,
  input wire logic                        source_send_ready,
  input wire tpm_pkg::tpm_beat_t          macTxBeat,
  input wire tpm_pkg::tpm_rx_t            macRx,
  input wire tpm_pkg::tpm_rx_t [3:0]      engineRx,
  input wire logic [tpm_pkg::TPM_SEL_W-1:0] activeChannelSelect
);
  import tpm_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  function automatic logic [1:0] rr_pick(input logic [1:0] s, input logic [3:0] v);
    for (int k = 1; k <= 4; k++) if (v[2'(s + k)]) return 2'(s + k);
    return s;
  endfunction
  // ==========================================================================
  // Properties
  hold_out_a: assert property (source_send_valid && !source_send_ready |=> source_send_valid && $stable(macTxBeat))
    else $error("MAC outputs moved in stall");
  grant_ready_a: assert property ((sourceSendReady & ~(4'h1 << activeChannelSelect)) == 4'h0)
    else $error("ready on ungranted channel");
  stall_ready_a: assert property (!source_send_ready |-> sourceSendReady == 4'h0)
    else $error("source ready high in MAC stall");
  sel_hold_a: assert property (|sourceSendReady |=> $stable(activeChannelSelect))
    else $error("switch inside packet");
  round_robin_a: assert property (!$stable(activeChannelSelect) |->
    activeChannelSelect == rr_pick($past(activeChannelSelect), $past(sourceSendValid)))
    else $error("wrong grant order");
  first_after_last_a: assert property (source_send_valid && source_send_ready && macTxBeat.last ##1 source_send_valid
    |-> macTxBeat.first)
    else $error("packet start missing");
  idle_keep_a: assert property (sourceSendValid == 4'h0 && !source_send_valid && sourceSendReady == 4'h0
    |=> $stable(activeChannelSelect))
    else $error("selector moved while idle");
  rx_fan_a: assert property (engineRx == {4{macRx}})
    else $error("receive fanout differs");
  req_served_a: assert property (|sourceSendValid |-> ##[0:60] |sourceSendReady)
    else $error("request never granted");
  cover property (source_send_valid && !source_send_ready);
  cover property (!$stable(activeChannelSelect));
  cover property (source_send_valid && source_send_ready && macTxBeat.last);
endmodule
bind tpm_merge tpm_merge_assertions chk (.ref_clk, .resetn, .sourceSendValid, .sourceSendReady,
  .sourceBeat, .source_send_valid, .source_send_ready, .macTxBeat, .macRx, .engineRx, .activeChannelSelect);
`default_nettype wire

// ===== verification/tpm_mac_model.sv
// MAC transmit sink model: records beats, can stall
// Shares ref_clk and resetn with the merge
`timescale 1ns/1ps
`default_nettype none
module tpm_mac_model (
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic [1:0]         mode,
  input  wire logic               source_send_valid,
  input  wire tpm_pkg::tpm_beat_t macTxBeat,
  output logic                    source_send_ready
);
  import tpm_pkg::*;
  tpm_beat_t  got[$];
  logic [1:0] tick;
  // ==========================================================================
  // Mode 0 prompt, 1 ready one cycle in three, 2 stopped
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick <= 2'h0;
      source_send_ready <= 1'b0;
    end else begin
      if (source_send_valid && source_send_ready) got.push_back(macTxBeat);
      tick <= (tick == 2'h2) ? 2'h0 : tick + 2'h1;
      source_send_ready <= (mode == 2'h0) || (mode == 2'h1 && tick == 2'h0);
    end
  end
endmodule
`default_nettype wire

// ===== verification/tpm_merge_tb.sv
// Testbench for the four-way transmit packet merge
// Bench sources on four channels, tpm_mac_model as MAC sink
`timescale 1ns/1ps
`default_nettype none
module tpm_merge_tb;
  import tpm_pkg::*;
  logic            ref_clk = 1'b0;
  logic            resetn = 1'b0;
  logic [3:0]      sourceSendValid = 4'h0;
  logic [3:0]      sourceSendReady;
  tpm_beat_t [3:0] sourceBeat = '0;
  logic            source_send_valid;
  logic            source_send_ready;
  tpm_beat_t       macTxBeat;
  tpm_rx_t         macRx = '0;
  tpm_rx_t [3:0]   engineRx;
  logic [1:0]      activeChannelSelect;
  logic [1:0]      mode = 2'h0;
  int              err_count = 0;
  int              comparisons = 0;
  int              ptr = 0;
  tpm_beat_t       srcQ[4][$];
  tpm_merge uut (.ref_clk, .resetn, .sourceSendValid, .sourceSendReady, .sourceBeat,
    .source_send_valid, .source_send_ready, .macTxBeat, .macRx, .engineRx, .activeChannelSelect);
  tpm_mac_model mac (.ref_clk, .resetn, .mode, .source_send_valid, .macTxBeat, .source_send_ready);
  initial forever #12.5 ref_clk = ~ref_clk;
  // ==========================================================================
  // Sources hold each beat until taken
  always @(posedge ref_clk) begin
    for (int c = 0; c < 4; c++) begin
      if (sourceSendValid[c] && sourceSendReady[c]) void'(srcQ[c].pop_front());
      sourceSendValid[c] <= srcQ[c].size() != 0;
      if (srcQ[c].size() != 0) sourceBeat[c] <= srcQ[c][0];
    end
  end
  function automatic tpm_beat_t mk(input int c, input int i, input int n);
    mk.first = i == 0;
    mk.last = i == n - 1;
    mk.word = {64{8'(c * 16 + i)}};
  endfunction
  task automatic chk(input string what, input logic [TPM_BEAT_W:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input int c, input int n);
    for (int i = 0; i < n; i++) srcQ[c].push_back(mk(c, i, n));
  endtask
  task automatic expect_pkt(input int c, input int n);
    for (int i = 0; i < n; i++) begin
      for (int t = 0; t < 200 && mac.got.size() <= ptr; t++) @(posedge ref_clk);
      chk("mac beat", mac.got[ptr], mk(c, i, n));
      ptr++;
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_pair();
    @(negedge ref_clk);
    send(1, 2);
    send(0, 3);
    expect_pkt(0, 3);
    expect_pkt(1, 2);
    repeat (4) @(posedge ref_clk);
    chk("select", activeChannelSelect, 2'h1);
    chk("idle valid", source_send_valid, 1'b0);
    $display("t_pair done");
  endtask
  task automatic t_ring();
    @(negedge ref_clk);
    for (int c = 0; c < 4; c++) send(c, 2);
    for (int c = 2; c < 6; c++) expect_pkt(c % 4, 2);
    $display("t_ring done");
  endtask
  task automatic t_stall();
    @(posedge ref_clk);
    mode <= 2'h1;
    @(negedge ref_clk);
    send(2, 6);
    expect_pkt(2, 6);
    @(posedge ref_clk);
    mode <= 2'h0;
    $display("t_stall done");
  endtask
  task automatic t_full();
    @(posedge ref_clk);
    mode <= 2'h2;
    @(negedge ref_clk);
    send(3, 14);
    repeat (30) @(posedge ref_clk);
    chk("stalled ready", sourceSendReady, 4'h0);
    mode <= 2'h0;
    expect_pkt(3, 14);
    $display("t_full done");
  endtask
  task automatic t_rx();
    @(posedge ref_clk);
    macRx <= '{valid: 1'b1, first: 1'b1, last: 1'b0, word: {16{32'hA5C30F1E}}};
    @(negedge ref_clk);
    for (int k = 0; k < 4; k++) chk("engine rx", engineRx[k], macRx);
    $display("t_rx done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    t_pair();
    t_ring();
    t_stall();
    t_full();
    t_rx();
    report_and_stop();
  end
  // Tests need about 110 cycles; eighteen times that is a hang
  initial begin
    repeat (2000) @(posedge ref_clk);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
